// *** prts_hyst.sv ***
// Hysteresis / window comparator shared by both front ends.
// Assumes signed operands; the enable marks an evaluation instant.
`timescale 1ns/1ps
`default_nettype none
module prts_hyst #(
   parameter int W = 32
) (
   input  wire logic                core_clk_i,
   input  wire logic                reset_i,
   input  wire logic                eval_i,
   input  wire logic signed [W-1:0] value_i,
   input  wire logic signed [W-1:0] on_i,
   input  wire logic signed [W-1:0] off_i,
   output logic                     q_o
);
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         q_o <= 1'b0;
      end else if (eval_i) begin
         if (on_i >= off_i) begin
            if (value_i > on_i)        q_o <= 1'b1;
            else if (value_i <= off_i) q_o <= 1'b0;
         end else begin
            q_o <= (value_i >= on_i) && (value_i < off_i);
         end
      end
   end
endmodule : prts_hyst
`default_nettype wire

// *** prts_pkg.sv ***
// Package for the pulse-rate and level threshold switch.
// Assumes one 25 MHz core clock and a synchronous active-high reset.
package prts_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned TICK_HZ         = 100;
   localparam int unsigned TICK_CYC        = CLK_HZ / TICK_HZ;
   localparam int unsigned GATE_MAX_CS     = 9999;
   localparam int unsigned FAST_PULSE_HZ   = 5000;
   localparam int unsigned SLOW_PULSE_HZ   = 4;
   // ---------------------------------------------------------------
   // Ranges and scaling
   // ---------------------------------------------------------------
   localparam int          CNT_LEVEL_MAX   = 9999;
   localparam int          GAIN_MAX_CENTI  = 1000;
   localparam int          OFFSET_MAX      = 10000;
   localparam int          ALEVEL_MAX      = 20000;
   localparam int          AIN_FULL_SCALE  = 1000;
   localparam int          GAIN_DIV        = 100;
   localparam int          DEC_MAX         = 3;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_COUNT       = 32'h0000_0000;
   localparam logic [23:0] RST_TICK        = 24'h00_0000;
   localparam logic [15:0] RST_GATE        = 16'h0000;
   typedef enum logic [0:0] {
      PRTS_SRC_PULSE  = 1'b0,
      PRTS_SRC_ANALOG = 1'b1
   } prts_src_t;
endpackage : prts_pkg

// *** prts_pulse_src.sv ***
// Pulse source standing in for the signal wired to the switch's pulse pin.
// Assumes a free-running core clock; the pin idles low between bursts.
`timescale 1ns/1ps
`default_nettype none
module prts_pulse_src (
   input  wire logic        core_clk_i,
   input  wire logic        go_i,
   input  wire logic [15:0] count_i,
   input  wire logic [7:0]  half_i,
   output logic             pulse_o,
   output logic             busy_o
);
   initial begin
      pulse_o = 1'b0;
      busy_o  = 1'b0;
      forever begin
         @(posedge core_clk_i);
         if (go_i) begin
            busy_o = 1'b1;
            // Each unit is one full high and low phase, so falls are as many as rises.
            repeat (count_i) begin
               @(negedge core_clk_i);
               pulse_o = 1'b1;
               repeat (half_i) @(negedge core_clk_i);
               pulse_o = 1'b0;
               repeat (half_i) @(negedge core_clk_i);
            end
            busy_o = 1'b0;
         end
      end
   end
endmodule : prts_pulse_src
`default_nettype wire

// *** prts_switch.sv ***
// Pulse-rate and level threshold switch: top module.
// Assumes parameters arrive as levels on the core clock domain, from the
// user program or from the live values of other blocks.
//
// Summary of operation
// - Count only rising edges of the pulse input.
// - Count correctly up to 5 kHz from a fast input.
// - Ordinary inputs need only about 4 Hz counting.
// - Gate time spans zero to 99.99 seconds, fixed seconds timebase.
// - Measured count equals rising edges within one gate interval.
// - Compare the pulse count once per gate interval; the analog value is compared every cycle.
// - With a one-second gate the count is frequency in hertz.
// - Pulse thresholds on and off range from 0 to 9999.
// - On at least off: set above on, clear at or below off.
// - On below off: set only when on <= value < off.
// - Analog compared value is input times gain plus offset.
// - Gain spans -10.00 to 10.00 in hundredths.
// - Offset spans -10000 to 10000.
// - Analog thresholds span -20000 to 20000, compared signed.
// - Decimal places affect display only, never the comparison.
// - Full-scale analog input maps to 1000, zero to zero.
// - Gate time may track a live value from another block.
// - Analog thresholds may track live values, including a count.
`timescale 1ns/1ps
`default_nettype none
module prts_switch
   import prts_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input  wire logic               core_clk_i,
   input  wire logic               reset_i,
   input  wire logic               src_analog_i,
   input  wire logic               pulse_i,
   input  wire logic [15:0]        gate_const_cs_i,
   input  wire logic               gate_from_live_i,
   input  wire logic [15:0]        gate_live_cs_i,
   input  wire logic [13:0]        cnt_on_i,
   input  wire logic [13:0]        cnt_off_i,
   input  wire logic signed [15:0] analog_value_i,
   input  wire logic signed [10:0] gain_centi_i,
   input  wire logic signed [14:0] offset_i,
   input  wire logic signed [15:0] a_on_const_i,
   input  wire logic signed [15:0] a_off_const_i,
   input  wire logic               a_on_from_live_i,
   input  wire logic               a_off_from_live_i,
   input  wire logic signed [15:0] a_on_live_i,
   input  wire logic signed [15:0] a_off_live_i,
   input  wire logic [1:0]         decimals_i,
   output logic                    switch_q_o,
   output logic [31:0]             measured_count_o,
   output logic signed [31:0]      actual_value_o,
   output logic                    gate_tick_o
);
   // ---------------------------------------------------------------
   // Pulse capture
   // ---------------------------------------------------------------
   // The pin passes two flops; the edge detector only reads the synchronised copy.
   // At 25 MHz a 5 kHz input has 5000 clocks per period, so no edge is missed.
   logic pulse_s;
   logic pulse_prev_q;
   logic rise;
   prts_sync u_sync (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .async_i    (pulse_i),
      .sync_o     (pulse_s)
   );
   always_ff @(posedge core_clk_i) begin
      if (reset_i) pulse_prev_q <= 1'b0;
      else         pulse_prev_q <= pulse_s;
   end
   assign rise = pulse_s & ~pulse_prev_q;

   // ---------------------------------------------------------------
   // Gate timing in hundredths of a second
   // ---------------------------------------------------------------
   logic [23:0] tick_cnt_q;
   logic        tick;
   logic [15:0] gate_cs;
   logic [15:0] gate_cnt_q;
   logic        gate_end;
   always_ff @(posedge core_clk_i) begin
      if (reset_i)                                 tick_cnt_q <= RST_TICK;
      else if (tick_cnt_q == 24'(TICK_CYCLES - 1)) tick_cnt_q <= RST_TICK;
      else                                         tick_cnt_q <= tick_cnt_q + 24'h00_0001;
   end
   assign tick = (tick_cnt_q == 24'(TICK_CYCLES - 1));
   // Seconds timebase is fixed; out-of-range values saturate at 99.99 s.
   always_comb begin
      gate_cs = gate_from_live_i ? gate_live_cs_i : gate_const_cs_i;
      if (gate_cs > 16'(GATE_MAX_CS)) gate_cs = 16'(GATE_MAX_CS);
   end
   // A zero gate closes every tick, the shortest interval the timer can resolve.
   always_ff @(posedge core_clk_i) begin
      if (reset_i)       gate_cnt_q <= RST_GATE;
      else if (gate_end) gate_cnt_q <= RST_GATE;
      else if (tick)     gate_cnt_q <= gate_cnt_q + 16'h0001;
   end
   assign gate_end = tick && ((gate_cnt_q + 16'h0001) >= gate_cs);

   // ---------------------------------------------------------------
   // Edge counting and latch
   // ---------------------------------------------------------------
   logic [31:0] edge_cnt_q;
   logic [31:0] edge_total;
   assign edge_total = edge_cnt_q + {31'h0000_0000, rise};
   always_ff @(posedge core_clk_i) begin
      if (reset_i)       edge_cnt_q <= RST_COUNT;
      else if (gate_end) edge_cnt_q <= RST_COUNT;
      else               edge_cnt_q <= edge_total;
   end
   // An edge in the closing cycle belongs to the closing interval.
   always_ff @(posedge core_clk_i) begin
      if (reset_i)       measured_count_o <= RST_COUNT;
      else if (gate_end) measured_count_o <= edge_total;
   end
   logic eval_q;
   always_ff @(posedge core_clk_i) begin
      if (reset_i) eval_q <= 1'b0;
      else         eval_q <= gate_end;
   end

   // ---------------------------------------------------------------
   // Analog scaling
   // ---------------------------------------------------------------
   // The input is already on the 0..1000 full-scale grid; gain is in hundredths.
   logic signed [31:0] gain_sat;
   logic signed [31:0] off_sat;
   logic signed [31:0] prod;
   logic signed [31:0] scaled;
   function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input int lim);
      logic signed [31:0] l;
      l = 32'(lim);
      if (v > l)       clamp = l;
      else if (v < -l) clamp = -l;
      else             clamp = v;
   endfunction : clamp
   always_comb begin
      gain_sat = clamp(32'(gain_centi_i), GAIN_MAX_CENTI);
      off_sat  = clamp(32'(offset_i), OFFSET_MAX);
      prod     = 32'(analog_value_i) * gain_sat;
      scaled   = (prod / 32'(GAIN_DIV)) + off_sat;
   end
   always_ff @(posedge core_clk_i) begin
      if (reset_i) actual_value_o <= 32'sh0000_0000;
      else         actual_value_o <= scaled;
   end

   // ---------------------------------------------------------------
   // Threshold selection
   // ---------------------------------------------------------------
   // The decimals setting is accepted but deliberately unused here.
   logic signed [31:0] on_sel;
   logic signed [31:0] off_sel;
   logic signed [31:0] val_sel;
   logic               eval_sel;
   logic               src_q;
   always_ff @(posedge core_clk_i) begin
      if (reset_i) src_q <= PRTS_SRC_PULSE;
      else         src_q <= src_analog_i;
   end
   always_comb begin
      if (src_q == PRTS_SRC_ANALOG) begin
         on_sel   = clamp(a_on_from_live_i ? 32'(a_on_live_i) : 32'(a_on_const_i),
                          ALEVEL_MAX);
         off_sel  = clamp(a_off_from_live_i ? 32'(a_off_live_i) : 32'(a_off_const_i),
                          ALEVEL_MAX);
         val_sel  = actual_value_o;
         eval_sel = 1'b1;
      end else begin
         on_sel   = clamp(32'(cnt_on_i), CNT_LEVEL_MAX);
         off_sel  = clamp(32'(cnt_off_i), CNT_LEVEL_MAX);
         val_sel  = measured_count_o;
         eval_sel = eval_q;
      end
   end
   prts_hyst #(.W(32)) u_hyst (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .eval_i     (eval_sel),
      .value_i    (val_sel),
      .on_i       (on_sel),
      .off_i      (off_sel),
      .q_o        (switch_q_o)
   );
   always_ff @(posedge core_clk_i) begin
      if (reset_i) gate_tick_o <= 1'b0;
      else         gate_tick_o <= gate_end;
   end

   // ---------------------------------------------------------------
   // Checks on counting and gate timing
   // ---------------------------------------------------------------
   // Cycles since the last gate end. It feeds only the checks below, which bound
   // every interval between one tick and the longest gate the timer accepts.
   logic [31:0] gate_len_q;
   always_ff @(posedge core_clk_i) begin
      if (reset_i)       gate_len_q <= RST_COUNT;
      else if (gate_end) gate_len_q <= RST_COUNT;
      else               gate_len_q <= gate_len_q + 32'h0000_0001;
   end
   chk_count_latch: assert property (@(posedge core_clk_i) disable iff (reset_i)
      gate_end |=> measured_count_o == $past(edge_total) && edge_cnt_q == 32'h0)
      else $error("measured count not latched at gate end");
   chk_fall_ignored: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (!rise && !gate_end) |=> edge_cnt_q == $past(edge_cnt_q))
      else $error("count moved without rising edge");
   chk_rise_counted: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (rise && !gate_end) |=> edge_cnt_q == $past(edge_cnt_q) + 32'h1)
      else $error("rising edge not counted");
   chk_rise_seen: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $rose(pulse_s) |-> rise)
      else $error("synchronised rise not detected");
   chk_fall_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $fell(pulse_s) |-> !rise)
      else $error("falling edge taken as a rise");
   chk_count_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !gate_end |=> $stable(measured_count_o))
      else $error("measured count moved inside a gate");

   chk_tick_range: assert property (@(posedge core_clk_i) disable iff (reset_i)
      tick_cnt_q < 24'(TICK_CYCLES))
      else $error("tick divider beyond its period");
   chk_tick_out: assert property (@(posedge core_clk_i) disable iff (reset_i)
      1'b1 |=> gate_tick_o == $past(gate_end))
      else $error("gate tick output not one cycle after gate end");
   chk_eval_follow: assert property (@(posedge core_clk_i) disable iff (reset_i)
      1'b1 |=> eval_q == $past(gate_end))
      else $error("evaluation strobe not tied to gate end");
   chk_gate_bound: assert property (@(posedge core_clk_i) disable iff (reset_i)
      gate_cnt_q <= 16'(GATE_MAX_CS))
      else $error("gate counter beyond limit");
   chk_gate_sat: assert property (@(posedge core_clk_i) disable iff (reset_i)
      gate_cs <= 16'(GATE_MAX_CS))
      else $error("gate time not saturated");
   chk_gate_live: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (gate_from_live_i && gate_live_cs_i <= 16'(GATE_MAX_CS)) |-> gate_cs == gate_live_cs_i)
      else $error("live gate time not tracked");
   chk_gate_max: assert property (@(posedge core_clk_i) disable iff (reset_i)
      gate_len_q < 32'(GATE_MAX_CS * TICK_CYCLES))
      else $error("gate interval longer than the longest gate");
   chk_gate_min: assert property (@(posedge core_clk_i) disable iff (reset_i)
      gate_end |-> gate_len_q >= 32'(TICK_CYCLES - 1))
      else $error("gate interval shorter than one tick");
   // Reset checks carry no disable clause, so they also run while reset is held.
   chk_reset_clear: assert property (@(posedge core_clk_i)
      reset_i |=> !switch_q_o && measured_count_o == 32'h0 && edge_cnt_q == 32'h0)
      else $error("reset did not clear state");
   chk_reset_timer: assert property (@(posedge core_clk_i)
      reset_i |=> tick_cnt_q == RST_TICK && gate_cnt_q == RST_GATE && !gate_tick_o)
      else $error("reset did not restart gate timing");

   // ---------------------------------------------------------------
   // Checks on the comparator and scaling
   // ---------------------------------------------------------------
   // The comparator checks watch the selected operands, so one set covers both front ends.
   chk_pulse_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (src_q == PRTS_SRC_PULSE && !eval_q && $past(src_q) == PRTS_SRC_PULSE) |=> $stable(switch_q_o))
      else $error("pulse output changed between gates");
   chk_idle_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !eval_sel |=> $stable(switch_q_o))
      else $error("output changed without evaluation");
   chk_hyst_set: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (eval_sel && on_sel >= off_sel && val_sel > on_sel) |=> switch_q_o)
      else $error("hysteresis output not set");
   chk_hyst_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (eval_sel && on_sel >= off_sel && val_sel <= off_sel) |=> !switch_q_o)
      else $error("hysteresis output not cleared");
   chk_hyst_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (eval_sel && on_sel >= off_sel && val_sel > off_sel && val_sel <= on_sel) |=> $stable(switch_q_o))
      else $error("hysteresis output not held in the band");
   chk_window_set: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (eval_sel && on_sel < off_sel && val_sel >= on_sel && val_sel < off_sel) |=> switch_q_o)
      else $error("window output not set");
   chk_window_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (eval_sel && on_sel < off_sel && (val_sel < on_sel || val_sel >= off_sel)) |=> !switch_q_o)
      else $error("window output not cleared");
   chk_pulse_levels: assert property (@(posedge core_clk_i) disable iff (reset_i)
      src_q == PRTS_SRC_PULSE |-> on_sel >= 32'sh0000_0000 && on_sel <= 32'(CNT_LEVEL_MAX)
         && off_sel >= 32'sh0000_0000 && off_sel <= 32'(CNT_LEVEL_MAX))
      else $error("pulse thresholds out of range");
   chk_analog_levels: assert property (@(posedge core_clk_i) disable iff (reset_i)
      src_q == PRTS_SRC_ANALOG |-> on_sel >= -32'(ALEVEL_MAX) && on_sel <= 32'(ALEVEL_MAX)
         && off_sel >= -32'(ALEVEL_MAX) && off_sel <= 32'(ALEVEL_MAX))
      else $error("analog thresholds out of range");
   chk_gain_clamp: assert property (@(posedge core_clk_i) disable iff (reset_i)
      gain_sat >= -32'(GAIN_MAX_CENTI) && gain_sat <= 32'(GAIN_MAX_CENTI))
      else $error("gain outside its range");
   chk_offset_clamp: assert property (@(posedge core_clk_i) disable iff (reset_i)
      off_sat >= -32'(OFFSET_MAX) && off_sat <= 32'(OFFSET_MAX))
      else $error("offset outside its range");
   // A zero input must leave only the offset, which pins the origin of the scale.
   chk_zero_input: assert property (@(posedge core_clk_i) disable iff (reset_i)
      analog_value_i == 16'sh0000 |=> actual_value_o == $past(off_sat))
      else $error("zero input not mapped to the offset");
   chk_scale_path: assert property (@(posedge core_clk_i) disable iff (reset_i)
      1'b1 |=> actual_value_o == $past(scaled))
      else $error("scaled value not registered");
endmodule : prts_switch
`default_nettype wire

// *** prts_switch_tb.sv ***
// Self-checking bench for the threshold switch, pulse and analog front ends.
// Assumes the tick divider is shortened to ten cycles for simulation.
`timescale 1ns/1ps
`default_nettype none
module prts_switch_tb;
   import prts_pkg::*;
   localparam int unsigned TCYC = 10;
   localparam int PN[11]   = '{10, 7, 5, 7, 9, 10, 10, 5, 4, 9, 60};
   localparam int PON[11]  = '{9, 9, 9, 9, 9, 9, 5, 5, 5, 5, 30};
   localparam int POFF[11] = '{5, 5, 5, 5, 5, 5, 10, 10, 10, 10, 70};
   localparam int PQ[11]   = '{1, 1, 0, 0, 0, 1, 0, 1, 0, 1, 1};
   localparam int AIN[7]  = '{1000, 600, 400, 1000, 3, 1000, 1000};
   localparam int AG[7]   = '{500, 500, 500, -1000, -150, 1000, 1000};
   localparam int AO[7]   = '{0, 0, 0, 10000, -1, -10000, 10000};
   localparam int AON[7]  = '{4000, 4000, 4000, 4000, -500, -20000, 19999};
   localparam int AOFF[7] = '{2000, 2000, 2000, 2000, 500, 0, -20000};
   localparam int ALIV[7] = '{0, 0, 0, 0, 1, 0, 0};
   localparam int AQ[7]   = '{1, 1, 0, 0, 1, 0, 1};
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               src, pulse, go, busy, tick, g_live, on_live, off_live, sw;
   logic [15:0]        g_const, g_lv, pcount;
   logic [13:0]        c_on, c_off;
   logic signed [15:0] ain, on_c, off_c, on_l, off_l;
   logic signed [10:0] gain;
   logic signed [14:0] offs;
   logic [1:0]         dec;
   logic [31:0]        meas;
   logic signed [31:0] actual;
   int                 fails = 0;
   int                 cmp_count = 0;
   int                 cyc = 0;
   int                 t0 = 0;
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   prts_switch #(.TICK_CYCLES(TCYC)) u_prts_switch (
      .core_clk_i(clk), .reset_i(rst), .src_analog_i(src), .pulse_i(pulse),
      .gate_const_cs_i(g_const), .gate_from_live_i(g_live), .gate_live_cs_i(g_lv),
      .cnt_on_i(c_on), .cnt_off_i(c_off), .analog_value_i(ain), .gain_centi_i(gain),
      .offset_i(offs), .a_on_const_i(on_c), .a_off_const_i(off_c),
      .a_on_from_live_i(on_live), .a_off_from_live_i(off_live), .a_on_live_i(on_l),
      .a_off_live_i(off_l), .decimals_i(dec), .switch_q_o(sw),
      .measured_count_o(meas), .actual_value_o(actual), .gate_tick_o(tick));
   prts_pulse_src u_prts_pulse_src (
      .core_clk_i(clk), .go_i(go), .count_i(pcount), .half_i(8'h02),
      .pulse_o(pulse), .busy_o(busy));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic wait_tick;
      int n;
      n = 0;
      while (tick !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) begin
         fails++;
         complete_run();
      end
   endtask : wait_tick
   task automatic send(input int n);
      int k;
      pcount = 16'(n);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 1000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 1000) begin
         fails++;
         complete_run();
      end
   endtask : send
   task do_reset;
      rst = 1'b1;
      repeat (8) @(negedge clk);
      check("switch", 32'(sw), 32'h0);
      check("count", meas, 32'h0);
      check("actual", actual, 32'h0);
      check("tick", 32'(tick), 32'h0);
      rst = 1'b0;
   endtask : do_reset
   initial begin
      {src, go, g_live, on_live, off_live} = 5'h00;
      {g_const, g_lv, pcount} = {16'h0014, 16'h0064, 16'h0000};
      {c_on, c_off, ain, on_c, off_c, on_l, off_l} = '0;
      {gain, offs, dec} = '0;
      @(negedge clk);
      do_reset();
      wait_tick();
      t0 = cyc;
      for (int i = 0; i < 11; i++) begin
         c_on = 14'(PON[i]);
         c_off = 14'(POFF[i]);
         g_live = (i == 10);
         send(PN[i]);
         wait_tick();
         check("gate period", 32'(cyc - t0), 32'((g_live ? g_lv : g_const) * TCYC));
         t0 = cyc;
         check("count", meas, 32'(PN[i]));
         @(negedge clk);
         check("switch", 32'(sw), 32'(PQ[i]));
         check("tick", 32'(tick), 32'h0);
      end
      $display("test pulse front end done");
      do_reset();
      src = 1'b1;
      for (int i = 0; i < 7; i++) begin
         ain = 16'(AIN[i]);
         gain = 11'(AG[i]);
         offs = 15'(AO[i]);
         dec = 2'(i);
         on_live = ALIV[i][0];
         off_live = ALIV[i][0];
         // The unselected source holds a decoy so a wrong pick shows up.
         on_c = ALIV[i] ? 16'sh1e61 : 16'(AON[i]);
         off_c = ALIV[i] ? -16'sh1e61 : 16'(AOFF[i]);
         on_l = ALIV[i] ? 16'(AON[i]) : 16'sh1e61;
         off_l = ALIV[i] ? 16'(AOFF[i]) : -16'sh1e61;
         repeat (3) @(negedge clk);
         check("actual", actual, 32'((AIN[i] * AG[i]) / 100 + AO[i]));
         check("switch", 32'(sw), 32'(AQ[i]));
      end
      $display("test analog front end done");
      complete_run();
   end
endmodule : prts_switch_tb
`default_nettype wire

// *** prts_sync.sv ***
// Two-stage synchroniser for the pulse pin.
// Assumes the pin is asynchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module prts_sync (
   input  wire logic core_clk_i,
   input  wire logic reset_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : prts_sync
`default_nettype wire
